//--- mad_core.sv
// Execution datapath: moves, arithmetic, logic, swaps and flag updates
// Behaviour
// RULE1 - add with carry sums A, M, carry
// RULE2 - plain add sets carry, decimal carry, zero
// RULE3 - immediate add to accumulator, one cycle
// RULE4 - subtract with borrow uses inverted carry
// RULE5 - plain subtract: carry low means borrow
// RULE6 - bank zero add writes bank zero
// RULE7 - decimal adjust in one cycle, carry only
// RULE8 - multiply two cycles, high byte to aux
// RULE9 - table read two cycles, aux and accumulator
// RULE10 - memory load sets zero, immediate load and stores keep flags
// RULE11 - immediate store only to working registers
// RULE12 - exchange swaps, flags unchanged
// RULE13 - logic ops update zero only
// RULE14 - nibble swap into accumulator
// RULE15 - nibble swap in place
// RULE16 - decoded operation selector from decode
// RULE17 - all results commit at final cycle
`timescale 1ns/1ps
`include "mad_defs.svh"
module mad_core import mad_pkg::*; #(
    parameter int DATA_W = `MAD_DATA_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Request from decode, operand and table data from memory
    input wire logic req_valid,
    input wire mad_req_t req,
    input wire logic [7:0] mem_rdata,
    input wire logic [15:0] rom_rdata,
    // Results
    output logic busy_q,
    output logic done_q,
    output logic [1:0] cycles_q,
    output logic reject_q,
    output logic [7:0] acc_q,
    output logic [7:0] aux_q,
    output mad_flags_t flags_q,
    output mad_wr_t wr_q,
    output logic [15:0] rom_addr_q
);
    typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_TBL} mad_st_t;
    mad_st_t st_q, st_d;
    logic busy_d, done_d, reject_d;
    logic [1:0] cycles_d;
    logic [7:0] acc_d, aux_d, yidx_q, yidx_d, zidx_q, zidx_d;
    mad_flags_t flags_d;
    mad_wr_t wr_d;
    logic [15:0] rom_addr_d;
    logic mul_load;
    logic [15:0] prod;
    logic [7:0] opnd, res, lo_adj;
    logic [8:0] sum9;
    logic [4:0] sum5;
    initial begin
        if (DATA_W != 8) $error("mad_core supports only 8-bit data");
    end

    function automatic logic is_work_reg(input logic [7:0] a);
        return a == `MAD_WREG_AUX || a == `MAD_WREG_ZIDX || a == `MAD_WREG_YIDX ||
            a == `MAD_WREG_BANK || a == `MAD_WREG_PROGRAM_FLAG_REGISTER;
    endfunction : is_work_reg

    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction : swap_nib

    mad_mult #(.W(8)) u_mult (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .load(mul_load),
        .a(acc_q),
        .b(mem_rdata),
        .prod_q(prod)
    );

    always_comb begin
        st_d = st_q;
        busy_d = 1'b0;
        done_d = 1'b0;
        reject_d = 1'b0;
        cycles_d = cycles_q;
        acc_d = acc_q;
        aux_d = aux_q;
        yidx_d = yidx_q;
        zidx_d = zidx_q;
        flags_d = flags_q;
        wr_d = '0;
        rom_addr_d = rom_addr_q;
        mul_load = 1'b0;
        opnd = req.use_imm ? req.imm : mem_rdata;
        sum9 = 9'h000;
        sum5 = 5'h00;
        res = 8'h00;
        lo_adj = 8'h00;
        case (st_q)
            ST_IDLE: begin
                if (req_valid) begin
                    // RULE16 decoded selector in
                    case (req.op)
                        // RULE10 loads and stores
                        MAD_OP_MOV_AM: begin
                            acc_d = mem_rdata;
                            flags_d.zero = (mem_rdata == 8'h00);
                        end
                        MAD_OP_MOV_MA: begin
                            wr_d = '{we: 1'b1, bank_zero: req.bank_zero, addr: req.addr,
                                data: acc_q};
                        end
                        MAD_OP_MOV_AI: acc_d = req.imm;
                        MAD_OP_MOV_MI: begin
                            // RULE11 working registers only
                            if (is_work_reg(req.addr)) begin
                                wr_d = '{we: 1'b1, bank_zero: 1'b1, addr: req.addr,
                                    data: req.imm};
                                if (req.addr == `MAD_WREG_AUX) aux_d = req.imm;
                                if (req.addr == `MAD_WREG_YIDX) yidx_d = req.imm;
                                if (req.addr == `MAD_WREG_ZIDX) zidx_d = req.imm;
                            end else begin
                                reject_d = 1'b1;
                            end
                        end
                        MAD_OP_XCH: begin
                            // RULE12 swap, flags kept
                            acc_d = mem_rdata;
                            wr_d = '{we: 1'b1, bank_zero: req.bank_zero, addr: req.addr,
                                data: acc_q};
                        end
                        MAD_OP_ADC, MAD_OP_ADD, MAD_OP_SBC, MAD_OP_SUB: begin
                            // RULE1 RULE2 RULE3 add paths
                            if (req.op == MAD_OP_ADC || req.op == MAD_OP_ADD) begin
                                sum9 = {1'b0, acc_q} + {1'b0, opnd} +
                                    {8'h00, (req.op == MAD_OP_ADC) & flags_q.carry};
                                sum5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} +
                                    {4'h0, (req.op == MAD_OP_ADC) & flags_q.carry};
                            end else begin
                                // RULE4 RULE5 carry set means no borrow
                                sum9 = {1'b0, acc_q} + {1'b0, ~opnd} +
                                    {8'h00, (req.op == MAD_OP_SUB) | flags_q.carry};
                                sum5 = {1'b0, acc_q[3:0]} + {1'b0, ~opnd[3:0]} +
                                    {4'h0, (req.op == MAD_OP_SUB) | flags_q.carry};
                            end
                            res = sum9[7:0];
                            flags_d = '{carry: sum9[8], dcarry: sum5[4], zero: res == 8'h00};
                            // RULE6 bank zero target when flagged
                            if (req.dst_mem) begin
                                wr_d = '{we: 1'b1, bank_zero: req.bank_zero, addr: req.addr,
                                    data: res};
                            end else begin
                                acc_d = res;
                            end
                        end
                        MAD_OP_DAA: begin
                            // RULE7 decimal adjust, carry only
                            lo_adj = (acc_q[3:0] > `MAD_BCD_LIMIT || flags_q.dcarry) ?
                                {4'h0, `MAD_BCD_FIX} : 8'h00;
                            sum9 = {1'b0, acc_q} + {1'b0, lo_adj};
                            if (sum9[7:4] > `MAD_BCD_LIMIT || flags_q.carry || sum9[8]) begin
                                sum9 = sum9 + {1'b0, `MAD_BCD_FIX, 4'h0};
                            end
                            acc_d = sum9[7:0];
                            flags_d.carry = sum9[8] || (acc_q > 8'h99) ||
                                flags_q.carry;
                        end
                        MAD_OP_MUL: begin
                            mul_load = 1'b1;
                            st_d = ST_MUL;
                            busy_d = 1'b1;
                        end
                        MAD_OP_TBL: begin
                            // RULE9 address from index pair
                            rom_addr_d = {yidx_q, zidx_q};
                            st_d = ST_TBL;
                            busy_d = 1'b1;
                        end
                        MAD_OP_AND, MAD_OP_OR, MAD_OP_XOR: begin
                            // RULE13 zero only
                            res = (req.op == MAD_OP_AND) ? (acc_q & opnd) :
                                (req.op == MAD_OP_OR) ? (acc_q | opnd) : (acc_q ^ opnd);
                            flags_d.zero = (res == 8'h00);
                            if (req.dst_mem) begin
                                wr_d = '{we: 1'b1, bank_zero: req.bank_zero, addr: req.addr,
                                    data: res};
                            end else begin
                                acc_d = res;
                            end
                        end
                        // RULE14 swap into accumulator
                        MAD_OP_SWAP: acc_d = swap_nib(mem_rdata);
                        MAD_OP_NIBBLE_SWAP_IN_PLACE: begin
                            // RULE15 swap written back
                            wr_d = '{we: 1'b1, bank_zero: req.bank_zero, addr: req.addr,
                                data: swap_nib(mem_rdata)};
                        end
                        default: ;
                    endcase
                    if (req.op != MAD_OP_MUL && req.op != MAD_OP_TBL) begin
                        done_d = 1'b1;
                        cycles_d = `MAD_CYC_ONE;
                    end
                end
            end
            ST_MUL: begin
                // RULE8 RULE17 product commits at end
                acc_d = prod[7:0];
                aux_d = prod[15:8];
                flags_d.zero = (prod[7:0] == 8'h00);
                done_d = 1'b1;
                cycles_d = `MAD_CYC_TWO;
                st_d = ST_IDLE;
            end
            ST_TBL: begin
                acc_d = rom_rdata[7:0];
                aux_d = rom_rdata[15:8];
                done_d = 1'b1;
                cycles_d = `MAD_CYC_TWO;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // RULE17 single commit point
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            reject_q <= 1'b0;
            cycles_q <= 2'h0;
            acc_q <= 8'h00;
            aux_q <= 8'h00;
            yidx_q <= 8'h00;
            zidx_q <= 8'h00;
            flags_q <= '0;
            wr_q <= '0;
            rom_addr_q <= 16'h0000;
        end else if (clk_en) begin
            st_q <= st_d;
            busy_q <= busy_d;
            done_q <= done_d;
            reject_q <= reject_d;
            cycles_q <= cycles_d;
            acc_q <= acc_d;
            aux_q <= aux_d;
            yidx_q <= yidx_d;
            zidx_q <= zidx_d;
            flags_q <= flags_d;
            wr_q <= wr_d;
            rom_addr_q <= rom_addr_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_add_carry_out: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE2
        req.op == MAD_OP_ADD && !req.dst_mem && !req.use_imm ##1 clk_en |->
        ({flags_q.carry, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(mem_rdata)}))
        else $error("add result or carry wrong");
    a_adc_sum: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE1
        req.op == MAD_OP_ADC && !req.dst_mem |=> ({flags_q.carry, acc_q} ==
        {1'b0, $past(acc_q)} + {1'b0, $past(opnd)} + {8'h00, $past(flags_q.carry)}))
        else $error("add with carry wrong");
    a_addi_one_cycle: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE3
        req.op == MAD_OP_ADD && req.use_imm && !req.dst_mem |=> done_q && !busy_q)
        else $error("immediate add not one cycle");
    a_sub_borrow: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE5
        req.op == MAD_OP_SUB && !req.dst_mem |=>
        flags_q.carry == ($past(acc_q) >= $past(opnd)))
        else $error("subtract borrow flag wrong");
    a_sbc_borrow: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE4
        req.op == MAD_OP_SBC && !req.dst_mem |=> acc_q ==
        8'($past(acc_q) - $past(opnd) - {7'h00, !$past(flags_q.carry)}))
        else $error("subtract with borrow wrong");
    a_mul_two_cycles: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE8
        req.op == MAD_OP_MUL ##1 clk_en |=> done_q && cycles_q == 2'h2 &&
        {aux_q, acc_q} == {8'h00, $past(acc_q, 2)} * {8'h00, $past(mem_rdata, 2)})
        else $error("multiply wrong");
    a_movi_reject: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE11
        req.op == MAD_OP_MOV_MI && !is_work_reg(req.addr) |=> reject_q && !wr_q.we)
        else $error("immediate store not refused");
    a_xch_flags: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE12
        req.op == MAD_OP_XCH |=> $stable(flags_q) && wr_q.data == $past(acc_q) &&
        acc_q == $past(mem_rdata)) else $error("exchange wrong");
    a_swap_nibbles: assert property (clk_en && req_valid && st_q == ST_IDLE && // RULE14
        req.op == MAD_OP_SWAP |=> acc_q == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
        && !wr_q.we) else $error("nibble swap wrong");
    c_mul: cover property (clk_en && req_valid && req.op == MAD_OP_MUL ##2 done_q);
    c_tbl: cover property (clk_en && req_valid && req.op == MAD_OP_TBL ##2 done_q);
    c_add_carry: cover property (done_q && flags_q.carry && !$past(flags_q.carry));
    c_reject: cover property (reject_q);
endmodule : mad_core

//--- mad_defs.svh
// Constants of the execution datapath: cycle counts, register indices, widths
`ifndef MAD_DEFS_SVH
`define MAD_DEFS_SVH
`define MAD_DATA_W 8
`define MAD_CYC_ONE 2'h1
`define MAD_CYC_TWO 2'h2
`define MAD_WREG_AUX 8'h82
`define MAD_WREG_ZIDX 8'h83
`define MAD_WREG_YIDX 8'h84
`define MAD_WREG_BANK 8'h86
`define MAD_WREG_PROGRAM_FLAG_REGISTER 8'h8E
`define MAD_BCD_LIMIT 4'h9
`define MAD_BCD_FIX 4'h6
`endif

//--- mad_mem_model.sv
// Partner model: operand memory and program memory seen by the datapath
`timescale 1ns/1ps
module mad_mem_model import mad_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Datapath side
    input wire logic req_valid,
    input wire mad_req_t req,
    input wire mad_wr_t wr_q,
    input wire logic [15:0] rom_addr_q,
    output logic [7:0] mem_rdata,
    output logic [15:0] rom_rdata
);
    logic [7:0] mem [256];
    logic [15:0] word;
    logic mul_q;
    logic tbl_q;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 29 + 7);
        end
    end
    always @(posedge ref_clk) begin
        if (wr_q.we === 1'b1) begin
            mem[wr_q.addr] <= wr_q.data;
        end
    end
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mul_q <= 1'b0;
            tbl_q <= 1'b0;
        end else begin
            mul_q <= req_valid && req.op == MAD_OP_MUL;
            tbl_q <= req_valid && req.op == MAD_OP_TBL;
        end
    end
    // Outside its window a line shows the inverse, so a late sample cannot match by luck
    assign word = {rom_addr_q[7:0] ^ 8'h5A, rom_addr_q[15:8] + 8'h3C};
    assign rom_rdata = tbl_q ? word : ~word;
    assign mem_rdata = (req_valid || mul_q) ? mem[req.addr] : ~mem[req.addr];
endmodule : mad_mem_model

//--- mad_mult.sv
// Registered 8x8 multiplier used as the first stage of a multiply
`timescale 1ns/1ps
module mad_mult import mad_pkg::*; #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [2*W-1:0] prod_q
);
    logic [2*W-1:0] prod_d;
    initial begin
        if (W < 1) $error("mad_mult width must be positive");
    end
    always_comb begin
        prod_d = prod_q;
        if (load) begin
            prod_d = {{W{1'b0}}, a} * {{W{1'b0}}, b};
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prod_q <= '0;
        end else if (clk_en) begin
            prod_q <= prod_d;
        end
    end
endmodule : mad_mult

//--- mad_pkg.sv
// Types of the execution datapath
package mad_pkg;
    typedef enum logic [4:0] {
        MAD_OP_NONE, MAD_OP_MOV_AM, MAD_OP_MOV_MA, MAD_OP_MOV_AI, MAD_OP_MOV_MI,
        MAD_OP_XCH, MAD_OP_TBL, MAD_OP_ADC, MAD_OP_ADD, MAD_OP_SBC, MAD_OP_SUB,
        MAD_OP_DAA, MAD_OP_MUL, MAD_OP_AND, MAD_OP_OR, MAD_OP_XOR, MAD_OP_SWAP,
        MAD_OP_NIBBLE_SWAP_IN_PLACE
    } mad_op_t;
    typedef struct packed {
        mad_op_t op;
        logic use_imm;
        logic dst_mem;
        logic bank_zero;
        logic [7:0] addr;
        logic [7:0] imm;
    } mad_req_t;
    typedef struct packed {
        logic carry;
        logic dcarry;
        logic zero;
    } mad_flags_t;
    typedef struct packed {
        logic we;
        logic bank_zero;
        logic [7:0] addr;
        logic [7:0] data;
    } mad_wr_t;
endpackage : mad_pkg

//--- mcu_alu_move_datapath_tb.sv
// Self-checking bench of the execution datapath
`timescale 1ns/1ps
`include "mad_defs.svh"
module mcu_alu_move_datapath_tb import mad_pkg::*; ;
    logic ref_clk, reset_n, clk_en, req_valid, busy_q, done_q, reject_q;
    mad_req_t req;
    logic [7:0] mem_rdata, acc_q, aux_q, ea, ex, yi, zi;
    logic [15:0] rom_rdata, rom_addr_q;
    logic [1:0] cycles_q;
    mad_flags_t flags_q;
    mad_wr_t wr_q;
    logic ec, edc, ez;
    int err_count, tests_run, seed_v;
    mad_core uut (.ref_clk, .reset_n, .clk_en, .req_valid, .req, .mem_rdata, .rom_rdata,
        .busy_q, .done_q, .cycles_q, .reject_q, .acc_q, .aux_q, .flags_q, .wr_q, .rom_addr_q);
    mad_mem_model pm (.ref_clk, .reset_n, .req_valid, .req, .wr_q, .rom_addr_q, .mem_rdata,
        .rom_rdata);
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic run_op(input mad_op_t op, input logic ui, dm, bz, input logic [7:0] ad, im);
        logic [7:0] m, o, r, ed;
        logic [8:0] s;
        logic [15:0] p;
        logic ci, ew, er, wb;
        int n, nc;
        m = pm.mem[ad];
        o = ui ? im : m;
        ci = (op == MAD_OP_ADC) ? ec : (op == MAD_OP_SBC) ? ~ec : 1'b0;
        ew = dm;
        ed = 8'h00;
        er = 1'b0;
        wb = 1'b0;
        r = ea;
        nc = (op == MAD_OP_MUL || op == MAD_OP_TBL) ? 2 : 1;
        case (op)
            MAD_OP_MOV_AM: begin
                ea = m;
                ez = (m == 8'h00);
            end
            MAD_OP_MOV_MA: wb = 1'b1;
            MAD_OP_MOV_AI: ea = im;
            MAD_OP_MOV_MI: begin
                ed = im;
                if (!(ad inside {`MAD_WREG_AUX, `MAD_WREG_ZIDX, `MAD_WREG_YIDX, `MAD_WREG_BANK,
                    `MAD_WREG_PROGRAM_FLAG_REGISTER})) begin
                    ew = 1'b0;
                    er = 1'b1;
                end
                if (ad == `MAD_WREG_AUX) ex = im;
                if (ad == `MAD_WREG_ZIDX) zi = im;
                if (ad == `MAD_WREG_YIDX) yi = im;
            end
            MAD_OP_XCH: begin
                ed = ea;
                ea = m;
            end
            MAD_OP_TBL: begin
                ex = zi ^ 8'h5A;
                ea = yi + 8'h3C;
            end
            MAD_OP_ADC, MAD_OP_ADD: begin
                s = {1'b0, ea} + {1'b0, o} + {8'h00, ci};
                edc = ({1'b0, ea[3:0]} + {1'b0, o[3:0]} + {4'h0, ci}) > 5'h0F;
                {ec, r} = s;
                wb = 1'b1;
            end
            MAD_OP_SBC, MAD_OP_SUB: begin
                s = {1'b0, ea} - {1'b0, o} - {8'h00, ci};
                edc = {1'b0, ea[3:0]} >= ({1'b0, o[3:0]} + {4'h0, ci});
                ec = ~s[8];
                r = s[7:0];
                wb = 1'b1;
            end
            MAD_OP_DAA: begin
                if (ea[3:0] > 4'h9 || edc) r = r + 8'h06;
                if (ea > 8'h99 || ec || r[7:4] > 4'h9) begin
                    r = r + 8'h60;
                    ec = 1'b1;
                end
                ea = r;
            end
            MAD_OP_MUL: begin
                p = ea * m;
                {ex, ea} = p;
                ez = (p[7:0] == 8'h00);
            end
            MAD_OP_AND, MAD_OP_OR, MAD_OP_XOR: begin
                r = (op == MAD_OP_AND) ? ea & o : (op == MAD_OP_OR) ? ea | o : ea ^ o;
                wb = 1'b1;
            end
            MAD_OP_SWAP: ea = {m[3:0], m[7:4]};
            MAD_OP_NIBBLE_SWAP_IN_PLACE: ed = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (wb && !(op inside {MAD_OP_MOV_MA})) ez = (r == 8'h00);
        if (wb && dm) ed = r;
        else if (wb) ea = r;
        @(posedge ref_clk);
        req <= '{op, ui, dm, bz, ad, im};
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
        if (nc == 2) chk(busy_q === 1'b1 && done_q === 1'b0, "busy in first cycle");
        n = 1;
        while (done_q !== 1'b1 && reject_q !== 1'b1 && n < 3) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (!er) chk(n == nc && cycles_q === 2'(nc), {"cycle count ", op.name()});
        chk(acc_q === ea && aux_q === ex, {"acc or aux ", op.name()});
        chk(flags_q === {ec, edc, ez}, {"flags ", op.name()});
        chk(wr_q.we === ew && reject_q === er, {"write or refusal ", op.name()});
        if (ew) chk(wr_q.addr === ad && wr_q.data === ed && wr_q.bank_zero === bz,
            "write data");
        if (op == MAD_OP_TBL) chk(rom_addr_q === {yi, zi}, "table address");
        // Let the write land in the model before the next operand is looked up
        repeat (2) @(negedge ref_clk);
    endtask : run_op
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #(20 * 3000);
        err_count++;
        complete_run();
    end
    initial begin
        logic [7:0] wregs [7];
        mad_op_t ops [14];
        mad_op_t op;
        logic ui, dm;
        wregs = '{`MAD_WREG_AUX, `MAD_WREG_ZIDX, `MAD_WREG_YIDX, `MAD_WREG_BANK, `MAD_WREG_PROGRAM_FLAG_REGISTER,
            8'h85, 8'h20};
        ops = '{MAD_OP_ADC, MAD_OP_ADD, MAD_OP_SBC, MAD_OP_SUB, MAD_OP_AND, MAD_OP_OR, MAD_OP_XOR,
            MAD_OP_MOV_AM, MAD_OP_MOV_MA, MAD_OP_MOV_AI, MAD_OP_XCH, MAD_OP_SWAP, MAD_OP_NIBBLE_SWAP_IN_PLACE,
            MAD_OP_MUL};
        reset_n = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        {ea, ex, yi, zi, ec, edc, ez} = '0;
        err_count = 0;
        tests_run = 0;
        seed_v = $urandom(67811);
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        run_op(MAD_OP_MOV_AI, 1, 0, 0, 8'h00, 8'hFF);
        run_op(MAD_OP_ADD, 1, 0, 0, 8'h00, 8'h01);
        run_op(MAD_OP_ADC, 0, 0, 0, 8'h05, 8'h00);
        run_op(MAD_OP_ADD, 0, 1, 0, 8'h06, 8'h00);
        run_op(MAD_OP_ADD, 0, 1, 1, 8'h07, 8'h00);
        run_op(MAD_OP_SUB, 1, 0, 0, 8'h00, 8'hFF);
        run_op(MAD_OP_SBC, 0, 0, 0, 8'h09, 8'h00);
        run_op(MAD_OP_SBC, 0, 1, 0, 8'h0A, 8'h00);
        $display("arithmetic corners done");
        run_op(MAD_OP_MOV_AI, 1, 0, 0, 8'h00, 8'h19);
        run_op(MAD_OP_ADD, 1, 0, 0, 8'h00, 8'h28);
        run_op(MAD_OP_DAA, 0, 0, 0, 8'h00, 8'h00);
        foreach (wregs[i]) run_op(MAD_OP_MOV_MI, 1, 1, 1, wregs[i], 8'h30 + 8'(i));
        run_op(MAD_OP_TBL, 0, 0, 0, 8'h00, 8'h00);
        run_op(MAD_OP_MUL, 0, 0, 0, 8'h11, 8'h00);
        run_op(MAD_OP_XCH, 0, 1, 1, 8'h12, 8'h00);
        run_op(MAD_OP_SWAP, 0, 0, 0, 8'h13, 8'h00);
        run_op(MAD_OP_NIBBLE_SWAP_IN_PLACE, 0, 1, 0, 8'h14, 8'h00);
        run_op(MAD_OP_AND, 1, 0, 0, 8'h00, 8'h00);
        $display("move and table corners done");
        for (int k = 0; k < 80; k++) begin
            op = ops[$urandom_range(13)];
            ui = (op == MAD_OP_MOV_AI) || (op inside {MAD_OP_ADD, MAD_OP_SUB, MAD_OP_AND,
                MAD_OP_OR, MAD_OP_XOR} && $urandom_range(1) == 1);
            dm = (op inside {MAD_OP_MOV_MA, MAD_OP_XCH, MAD_OP_NIBBLE_SWAP_IN_PLACE}) || (!ui && op inside
                {MAD_OP_ADC, MAD_OP_ADD, MAD_OP_SBC, MAD_OP_SUB, MAD_OP_AND, MAD_OP_OR,
                MAD_OP_XOR} && $urandom_range(1) == 1);
            run_op(op, ui, dm, 1'($urandom_range(1)), 8'($urandom_range(127)), 8'($urandom));
        end
        $display("random sequence done");
        complete_run();
    end
endmodule : mcu_alu_move_datapath_tb
